// File: src/srci_regs.svh
// Opcodes, cycle counts and reset values for the stack/rotate/carry executor
`ifndef SRCI_REGS_SVH
`define SRCI_REGS_SVH

`define SRCI_OP_PUSH_R 8'h70
`define SRCI_OP_PUSH_IR 8'h71
`define SRCI_OP_PUSH_DN 8'h82
`define SRCI_OP_PUSH_UP 8'h83
`define SRCI_OP_CLR_C 8'hcf
`define SRCI_OP_SUB_EXIT 8'haf
`define SRCI_OP_ROL_R 8'h90
`define SRCI_OP_ROL_IR 8'h91
`define SRCI_OP_RLC_R 8'h10
`define SRCI_OP_RLC_IR 8'h11
`define SRCI_OP_ROR_R 8'he0
`define SRCI_OP_ROR_IR 8'he1
`define SRCI_OP_RRC_R 8'hc0

`define SRCI_CYC_PUSH 4'h8
`define SRCI_CYC_USTACK 4'h8
`define SRCI_CYC_CLR_C 4'h4
`define SRCI_CYC_SUB_EXIT 4'h8
`define SRCI_CYC_ROT 4'h4

`define SRCI_FLAG_C 7
`define SRCI_FLAG_Z 6
`define SRCI_FLAG_S 5
`define SRCI_FLAG_V 4

`define SRCI_SP_RESET 16'h0000
`define SRCI_PC_RESET 16'h0000

`endif

// File: src/srci_pkg.sv
// Types shared by the stack/rotate/carry executor
`default_nettype none
package srci_pkg;

	typedef enum logic [1:0] {
		SRCI_ROT_LEFT_CIRC,
		SRCI_ROT_LEFT_VIA_C,
		SRCI_ROT_RIGHT_CIRC,
		SRCI_ROT_RIGHT_VIA_C
	} srci_rot_kind_t;

	// Register file access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} srci_rf_req_t;

	// Stack memory access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} srci_mem_req_t;

	// Rotator result
	typedef struct packed {
		logic [7:0] value;
		logic [7:0] flags;
	} srci_rot_res_t;

endpackage
`default_nettype wire

// File: src/srci_rotator.sv
// Combinational one-bit rotator with flag update
`include "srci_regs.svh"
`default_nettype none
module srci_rotator
	import srci_pkg::*;
(
	// Operand and control
	input wire srci_rot_kind_t kind,
	input wire logic [7:0] operand,
	input wire logic [7:0] flags_in,
	// Result
	output srci_rot_res_t res
);

	logic [7:0] r;

	// Bit shuffle per kind
	always_comb begin
		case (kind)
			SRCI_ROT_LEFT_CIRC: r = {operand[6:0], operand[7]};
			SRCI_ROT_LEFT_VIA_C: r = {operand[6:0], flags_in[`SRCI_FLAG_C]};
			SRCI_ROT_RIGHT_CIRC: r = {operand[0], operand[7:1]};
			SRCI_ROT_RIGHT_VIA_C: r = {flags_in[`SRCI_FLAG_C], operand[7:1]};
			default: r = operand;
		endcase
	end

	// Flags; D, H and bank bits pass through untouched
	always_comb begin
		res.value = r;
		res.flags = flags_in;
		res.flags[`SRCI_FLAG_C] = (kind == SRCI_ROT_LEFT_CIRC || kind == SRCI_ROT_LEFT_VIA_C) ? operand[7]
			: operand[0];
		res.flags[`SRCI_FLAG_Z] = (r == 8'h00);
		res.flags[`SRCI_FLAG_S] = r[7];
		res.flags[`SRCI_FLAG_V] = r[7] ^ operand[7];
	end

endmodule
`default_nettype wire

// File: src/srci_exec.sv
// Execution unit for stack push, user stacks, carry clear, subroutine exit and rotates
`include "srci_regs.svh"
`default_nettype none
// Notes on behaviour
// - System push decrements the 16-bit stack pointer with wrap from zero to all ones, then stores the byte there.
// - Decrementing user push decrements the pointer register first, then writes the source to the new address.
// - Decrementing user push is opcode 82h, three bytes, indirect destination, register source, 8 cycles.
// - Incrementing user push increments the pointer register first, then writes the source to the new address.
// - Incrementing user push is opcode 83h, three bytes, indirect destination, register source, 8 cycles.
// - Pushes and the subroutine exit leave all flag bits unchanged.
// - Subroutine exit, opcode AFh, loads the program counter from the stack and adds two to the stack pointer.
// - The byte at the stack pointer becomes the high program counter byte, the next byte the low byte.
// - Circular left rotate copies old bit 7 into bit 0 and carry; 90h register, 91h indirect.
// - Left rotate via carry moves bit 7 to carry and old carry to bit 0; 10h register, 11h indirect.
// - Circular right rotate copies old bit 0 into bit 7 and carry; E0h register, E1h indirect.
// - Right rotate via carry moves bit 0 to carry and old carry to bit 7; C0h register.
// - Every rotate sets overflow when the sign bit changes and clears it otherwise.
// - Every rotate sets zero on a zero result, copies bit 7 into sign and keeps decimal and half-carry.
module srci_exec
	import srci_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Decoded instruction from fetch
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] op_a,
	input wire logic [7:0] op_b,
	output logic ready,
	output logic unknown_op,
	// Register file, read data valid the cycle after rd
	output srci_rf_req_t rf_req,
	input wire logic [7:0] rf_rdata,
	// Stack memory, read data valid the cycle after rd
	output srci_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	// Architectural state
	output logic [7:0] flags,
	output logic [15:0] stack_ptr,
	output logic [15:0] prog_ctr,
	output logic done
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_PTR_RD, ST_PTR_WB, ST_SRC_RD, ST_DATA_WR, ST_OPND_RD, ST_ROT_WB,
		ST_EXIT_HI, ST_EXIT_LO, ST_EXIT_END, ST_WAIT
	} srci_state_t;

	typedef struct packed {
		srci_state_t st;
		logic [7:0] op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] addr;
		logic [7:0] data;
		logic [3:0] cnt;
		logic [7:0] flags;
		logic [15:0] sp;
		logic [15:0] pc;
		srci_rf_req_t rf;
		srci_mem_req_t mem;
		logic done;
		logic bad;
	} srci_state_s_t;

	srci_state_s_t s, next_s;
	srci_rot_kind_t rot_kind;
	srci_rot_res_t rot_res;
	logic is_rot, rot_ind;

	// Rotate decode; kind also steers the shared rotator
	always_comb begin
		is_rot = 1'b1;
		rot_ind = 1'b0;
		rot_kind = SRCI_ROT_LEFT_CIRC;
		case (s.op)
			`SRCI_OP_ROL_R: rot_kind = SRCI_ROT_LEFT_CIRC;
			`SRCI_OP_ROL_IR: begin
				rot_kind = SRCI_ROT_LEFT_CIRC;
				rot_ind = 1'b1;
			end
			`SRCI_OP_RLC_R: rot_kind = SRCI_ROT_LEFT_VIA_C;
			`SRCI_OP_RLC_IR: begin
				rot_kind = SRCI_ROT_LEFT_VIA_C;
				rot_ind = 1'b1;
			end
			`SRCI_OP_ROR_R: rot_kind = SRCI_ROT_RIGHT_CIRC;
			`SRCI_OP_ROR_IR: begin
				rot_kind = SRCI_ROT_RIGHT_CIRC;
				rot_ind = 1'b1;
			end
			`SRCI_OP_RRC_R: rot_kind = SRCI_ROT_RIGHT_VIA_C;
			default: is_rot = 1'b0;
		endcase
	end

	srci_rotator u_rot (
		.kind(rot_kind),
		.operand(s.data),
		.flags_in(s.flags),
		.res(rot_res)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer: one access per cycle, then pad to the documented count
	always_comb begin
		next_s = s;
		next_s.rf = '0;
		next_s.mem = '0;
		next_s.done = 1'b0;
		next_s.bad = 1'b0;
		if (s.st != ST_IDLE)
			next_s.cnt = s.cnt - 4'h1;
		case (s.st)
			ST_IDLE: begin
				if (start) begin
					next_s.op = opcode;
					next_s.a = op_a;
					next_s.b = op_b;
					next_s.st = ST_PTR_RD;
					case (opcode)
						`SRCI_OP_PUSH_R, `SRCI_OP_PUSH_IR: begin
							next_s.cnt = `SRCI_CYC_PUSH - 4'h1;
							next_s.rf.rd = 1'b1;
							next_s.rf.addr = op_a;
							next_s.st = (opcode == `SRCI_OP_PUSH_IR) ? ST_SRC_RD : ST_DATA_WR;
						end
						`SRCI_OP_PUSH_DN, `SRCI_OP_PUSH_UP: begin
							next_s.cnt = `SRCI_CYC_USTACK - 4'h1;
							next_s.rf.rd = 1'b1;
							next_s.rf.addr = op_a;
						end
						`SRCI_OP_CLR_C: begin
							next_s.cnt = `SRCI_CYC_CLR_C - 4'h1;
							next_s.flags[`SRCI_FLAG_C] = 1'b0;
							next_s.st = ST_WAIT;
						end
						`SRCI_OP_SUB_EXIT: begin
							next_s.cnt = `SRCI_CYC_SUB_EXIT - 4'h1;
							next_s.mem.rd = 1'b1;
							next_s.mem.addr = s.sp;
							next_s.st = ST_EXIT_HI;
						end
						default: begin
							next_s.cnt = `SRCI_CYC_ROT - 4'h1;
							next_s.rf.rd = 1'b1;
							next_s.rf.addr = op_a;
							// Direct target; an indirect rotate replaces it with the pointer
							next_s.addr = op_a;
							next_s.st = ST_OPND_RD;
						end
					endcase
				end
			end
			// Pointer arrived: step it and write it back
			ST_PTR_RD: begin
				if (s.op == `SRCI_OP_PUSH_DN)
					next_s.addr = rf_rdata - 8'h01;
				else
					next_s.addr = rf_rdata + 8'h01;
				next_s.st = ST_PTR_WB;
			end
			ST_PTR_WB: begin
				next_s.rf.wr = 1'b1;
				next_s.rf.addr = s.a;
				next_s.rf.wdata = s.addr;
				next_s.rf.rd = 1'b0;
				next_s.st = ST_SRC_RD;
				// Source register read queued next cycle
			end
			ST_SRC_RD: begin
				next_s.rf.rd = 1'b1;
				if (s.op == `SRCI_OP_PUSH_IR)
					next_s.rf.addr = rf_rdata;
				else
					next_s.rf.addr = s.b;
				next_s.st = ST_DATA_WR;
				if (s.op == `SRCI_OP_PUSH_IR)
					next_s.op = `SRCI_OP_PUSH_R;
			end
			ST_DATA_WR: begin
				if (s.op == `SRCI_OP_PUSH_R) begin
					next_s.sp = s.sp - 16'h0001;
					next_s.mem.wr = 1'b1;
					next_s.mem.addr = s.sp - 16'h0001;
					next_s.mem.wdata = rf_rdata;
				end else begin
					next_s.rf.wr = 1'b1;
					next_s.rf.addr = s.addr;
					next_s.rf.wdata = rf_rdata;
				end
				next_s.st = ST_WAIT;
			end
			ST_OPND_RD: begin
				if (!is_rot) begin
					next_s.bad = 1'b1;
					next_s.st = ST_WAIT;
				end else if (rot_ind) begin
					next_s.rf.rd = 1'b1;
					next_s.rf.addr = rf_rdata;
					next_s.addr = rf_rdata;
					next_s.op = s.op & 8'hfe;
					next_s.st = ST_OPND_RD;
				end else begin
					// Target already held; a pointer of zero is a valid address
					next_s.data = rf_rdata;
					next_s.st = ST_ROT_WB;
				end
			end
			ST_ROT_WB: begin
				next_s.rf.wr = 1'b1;
				next_s.rf.addr = s.addr;
				next_s.rf.wdata = rot_res.value;
				next_s.flags = rot_res.flags;
				next_s.st = ST_WAIT;
			end
			// first byte is high
			// Data stands while the registered read does, as on the register file
			ST_EXIT_HI: begin
				next_s.pc[15:8] = mem_rdata;
				next_s.mem.rd = 1'b1;
				next_s.mem.addr = s.sp + 16'h0001;
				next_s.st = ST_EXIT_LO;
			end
			ST_EXIT_LO: begin
				next_s.pc[7:0] = mem_rdata;
				next_s.st = ST_EXIT_END;
			end
			ST_EXIT_END: begin
				next_s.sp = s.sp + 16'h0002;
				next_s.st = ST_WAIT;
			end
			ST_WAIT: begin
				if (s.cnt == 4'h0) begin
					next_s.done = 1'b1;
					next_s.addr = 8'h00;
					next_s.st = ST_IDLE;
				end
			end
			default: next_s.st = ST_IDLE;
		endcase
	end

	// State register; reset loads idle and the reset pointer values
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.sp <= `SRCI_SP_RESET;
			s.pc <= `SRCI_PC_RESET;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign ready = (s.st == ST_IDLE);
	assign unknown_op = s.bad;
	assign rf_req = s.rf;
	assign mem_req = s.mem;
	assign flags = s.flags;
	assign stack_ptr = s.sp;
	assign prog_ctr = s.pc;
	assign done = s.done;

endmodule
`default_nettype wire

// File: testbench/srci_exec_checker.sv
// Assertions on the stack, rotate and carry executor
`default_nettype none
module srci_exec_checker
	import srci_pkg::*;
(
	// Clock, reset and request
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic ready,
	input wire logic [7:0] opcode,
	input wire logic [7:0] op_a,
	// Memories
	input wire srci_rf_req_t rf_req,
	input wire logic [7:0] rf_rdata,
	input wire srci_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	// State
	input wire logic [7:0] flags,
	input wire logic [15:0] stack_ptr,
	input wire logic [15:0] prog_ctr,
	input wire logic done
);
	logic [7:0] op, sa, sf, rd, wv;
	logic [15:0] ssp, pc;
	logic stk, rot, lft, cir;
	////////////////////
	// Class of the running opcode
	assign stk = op inside {8'h70, 8'h71, 8'h82, 8'h83, 8'haf};
	assign rot = op inside {8'h90, 8'h91, 8'h10, 8'h11, 8'he0, 8'he1, 8'hc0};
	assign lft = op[7:4] inside {4'h9, 4'h1};
	assign cir = op[7:4] inside {4'h9, 4'he};
	// Context at acceptance; last read is the operand, so only op needs reset
	always_ff @(posedge mclk) begin
		if (!rst_n)
			op <= 8'h00;
		else if (start && ready)
			op <= opcode;
		if (start && ready) begin
			sa <= op_a;
			sf <= flags;
			ssp <= stack_ptr;
		end
		if (rf_req.rd)
			rd <= rf_rdata;
		if (rf_req.wr)
			wv <= rf_req.wdata;
		if (mem_req.rd && mem_req.addr == ssp)
			pc[15:8] <= mem_rdata;
		else if (mem_req.rd)
			pc[7:0] <= mem_rdata;
	end
	////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_PUSH_ADDR: assert property (mem_req.wr |-> mem_req.addr == ssp - 16'h0001 && mem_req.wdata == rd)
		else $error("push address or data wrong");
	AST_PUSH_SP: assert property (done && op inside {8'h70, 8'h71} |-> stack_ptr == ssp - 16'h0001)
		else $error("push pointer wrong");
	AST_KEEP_FLAGS: assert property (!ready && stk |-> $stable(flags))
		else $error("flags changed by stack op");
	AST_CLR_C: assert property (done && op == 8'hcf |-> flags == (sf & 8'h7f))
		else $error("carry clear wrong");
	AST_ROT_DATA: assert property (rf_req.wr && rot |->
		rf_req.wdata == (lft ? {rd[6:0], cir ? rd[7] : sf[7]} : {cir ? rd[0] : sf[7], rd[7:1]}))
		else $error("rotate result wrong");
	AST_ROT_CV: assert property (done && rot |-> flags[7] == (lft ? rd[7] : rd[0]) && flags[4] == (rd[7] ^ wv[7]))
		else $error("rotate carry or overflow wrong");
	AST_ROT_ZS: assert property (done && rot |-> {flags[6:5], flags[3:0]} == {wv == 8'h00, wv[7], sf[3:0]})
		else $error("rotate zero or sign wrong");
	AST_UPTR: assert property (rf_req.wr && op inside {8'h82, 8'h83} && rf_req.addr == sa |->
		rf_req.wdata == (op[0] ? rd + 8'h01 : rd - 8'h01))
		else $error("user pointer wrong");
	AST_EXIT_SP: assert property (done && op == 8'haf |-> stack_ptr == ssp + 16'h0002)
		else $error("exit pointer wrong");
	AST_EXIT_PC: assert property (done && op == 8'haf |-> prog_ctr == pc)
		else $error("exit counter wrong");
	// Main scenarios reached
	COV_PUSH: cover property (done && op == 8'h70);
	COV_EXIT: cover property (done && op == 8'haf);
	COV_ROT: cover property (done && op == 8'hc0);
endmodule
bind srci_exec srci_exec_checker i_chk (.mclk, .rst_n, .start, .ready, .opcode, .op_a, .rf_req, .rf_rdata,
	.mem_req, .mem_rdata, .flags, .stack_ptr, .prog_ctr, .done);
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench of the stack, rotate and carry executor
`default_nettype none
module testbench
	import srci_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst_n = 1'b0, start = 1'b0;
	logic [7:0] opcode = 8'h00, op_a = 8'h00, op_b = 8'h00, rf_rdata = 8'h00, mem_rdata = 8'h00;
	logic ready, unknown_op, done;
	srci_rf_req_t rf_req;
	srci_mem_req_t mem_req;
	logic [7:0] flags, exp_f;
	logic [15:0] stack_ptr, prog_ctr;
	logic [7:0] rf [256];
	logic [7:0] mem [65536];
	int err_count = 0, num_checks = 0, cyc;
	logic saw_bad = 1'b0;
	////////////////////
	srci_exec i_dut (.mclk(mclk), .rst_n(rst_n), .start(start), .opcode(opcode), .op_a(op_a), .op_b(op_b),
		.ready(ready), .unknown_op(unknown_op), .rf_req(rf_req), .rf_rdata(rf_rdata), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .flags(flags), .stack_ptr(stack_ptr), .prog_ctr(prog_ctr), .done(done));
	always #5 mclk = ~mclk;
	// Memories answer next cycle; idle data toggles so nothing stale passes
	always @(negedge mclk) begin
		if (rf_req.wr)
			rf[rf_req.addr] = rf_req.wdata;
		rf_rdata = rf_req.rd ? rf[rf_req.addr] : ~rf_rdata;
		if (mem_req.wr)
			mem[mem_req.addr] = mem_req.wdata;
		mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
		// Sticky mark of an unhandled-opcode pulse
		if (unknown_op === 1'b1)
			saw_bad = 1'b1;
	end
	////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One instruction; cyc counts cycles from acceptance to done
	task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
		@(negedge mclk);
		start = 1'b1;
		opcode = op;
		op_a = a;
		op_b = b;
		@(negedge mclk);
		start = 1'b0;
		cyc = 1;
		while (done !== 1'b1 && cyc < 50) begin
			@(negedge mclk);
			cyc++;
		end
		check(cyc < 50, 1'b1);
	endtask
	task automatic give_verdict();
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////
	// All rotate codes, direct and indirect, carry chained
	task automatic t_rot();
		logic [7:0] ops [7] = '{8'h90, 8'h91, 8'h10, 8'h11, 8'he0, 8'he1, 8'hc0};
		logic [7:0] vals [4] = '{8'haa, 8'h01, 8'h80, 8'h55};
		logic [7:0] v, r, ad;
		logic l, ci;
		foreach (ops[i]) foreach (vals[j]) begin
			v = vals[j];
			ad = ops[i][0] ? 8'h20 : 8'h01;
			rf[8'h01] = ops[i][0] ? 8'h20 : v;
			rf[8'h20] = v;
			l = ops[i][7:4] inside {4'h9, 4'h1};
			ci = ops[i][7:4] inside {4'h9, 4'he};
			r = l ? {v[6:0], ci ? v[7] : exp_f[7]} : {ci ? v[0] : exp_f[7], v[7:1]};
			exp_f = {l ? v[7] : v[0], r == 8'h00, r[7], v[7] ^ r[7], exp_f[3:0]};
			run(ops[i], 8'h01, 8'h00);
			check(rf[ad], r);
			check(flags, exp_f);
		end
		// Pointer holding zero must still steer the write
		rf[8'h01] = 8'h00;
		rf[8'h00] = 8'h81;
		run(8'h91, 8'h01, 8'h00);
		check(rf[8'h00], 8'h03);
		check(rf[8'h01], 8'h00);
		check(flags, 8'h90);
	endtask
	// Carry set first, then cleared
	task automatic t_clr();
		rf[8'h01] = 8'h80;
		run(8'h90, 8'h01, 8'h00);
		exp_f = 8'h90;
		check(flags, exp_f);
		run(8'hcf, 8'h00, 8'h00);
		exp_f = 8'h10;
		check(flags, exp_f);
		check(cyc == 5, 1'b1);
		// Clearing an already clear carry
		run(8'hcf, 8'h00, 8'h00);
		check(flags, exp_f);
	endtask
	// System push from zero wraps, then indirect push
	task automatic t_push();
		rf[8'h40] = 8'h4f;
		rf[8'h4f] = 8'haa;
		run(8'h70, 8'h40, 8'h00);
		check(stack_ptr, 16'hffff);
		check(mem[16'hffff], 8'h4f);
		run(8'h71, 8'h40, 8'h00);
		check(mem[16'hfffe], 8'haa);
		check(flags, exp_f);
	endtask
	// User stacks both ways, pointer wrap included
	task automatic t_ustack();
		logic [7:0] cs [3][3] = '{'{8'h82, 8'h03, 8'h02}, '{8'h83, 8'h03, 8'h04}, '{8'h82, 8'h00, 8'hff}};
		foreach (cs[i]) begin
			rf[8'h00] = cs[i][1];
			rf[8'h01] = 8'h05 + i[7:0];
			run(cs[i][0], 8'h00, 8'h01);
			check(rf[8'h00], cs[i][2]);
			check(rf[cs[i][2]], 8'h05 + i[7:0]);
			check(cyc == 9, 1'b1);
			check(flags, exp_f);
		end
	endtask
	// Return pops high byte first, pointer wraps to zero
	task automatic t_exit();
		mem[16'hfffe] = 8'h10;
		mem[16'hffff] = 8'h1a;
		run(8'haf, 8'h00, 8'h00);
		check(prog_ctr, 16'h101a);
		check(stack_ptr, 16'h0000);
		check(flags, exp_f);
		check(cyc == 9, 1'b1);
	endtask
	// Unhandled opcode is reported and leaves flags alone
	task automatic t_bad();
		check(saw_bad, 1'b0); // No pulse so far
		run(8'hff, 8'h00, 8'h00);
		check(saw_bad, 1'b1); // Unhandled opcode
		check(flags, exp_f); // Flags kept
	endtask
	////////////////////
	initial begin
		foreach (rf[i]) rf[i] = 8'h00;
		foreach (mem[i]) mem[i] = 8'h00;
		exp_f = 8'h00;
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		t_rot();
		t_clr();
		t_push();
		t_ustack();
		t_exit();
		t_bad();
		give_verdict();
	end
	// Hang guard, far beyond the expected run
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
